// [rtl/bus_sideband_pkg.sv]
package bus_sideband_pkg;
   // clocks and link timing
   localparam int MCLK_PERIOD_NS = 8;
   localparam int BUS_CLK_PERIOD_NS = 80;
   localparam int BUS_HALF_CYCLES = BUS_CLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   localparam int DIV_W = 8;
   localparam int RESET_HOLD_MS = 2;
   localparam int NS_PER_MS = 1000000;
   localparam int RESET_HOLD_CYCLES =
      (RESET_HOLD_MS * NS_PER_MS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int HOLD_W = 20;
   localparam int RESET_OFF_BUS_CLOCKS = 2;

   // link field widths and idle levels
   localparam int CMD_W = 5;
   localparam int RESP_W = 3;
   localparam int STRAP_W = 2;
   localparam int IRQ_W = 2;
   localparam logic [CMD_W-1:0] CMD_IDLE_N = 5'h1f;
   localparam logic [RESP_W-1:0] RESP_IDLE_N = 3'h7;
   localparam logic IRQ_CTRL_EN_RESET = 1'b1;

   // cpu end synchroniser vector layout
   localparam int DS_BCLK = 0;
   localparam int DS_RST_N = 1;
   localparam int DS_SUPPLY = 2;
   localparam int DS_LINT = 3;
   localparam int DS_PRIORITY_AGENT_BUS_ASK_N_N = 5;
   localparam int DS_DEBUG_PROBE_ASK_N_N = 6;
   localparam int DS_RESP = 7;
   localparam int DS_STRAP = 10;
   localparam int DS_W = 12;
   localparam logic [DS_W-1:0] DS_INIT = 12'h03e0;

   // chipset end synchroniser vector layout
   localparam int CS_LOCK_N = 0;
   localparam int CS_STB_N = 1;
   localparam int CS_THERM_N = 2;
   localparam int CS_PSI_N = 3;
   localparam int CS_DEBUG_PROBE_ACK_N_N = 4;
   localparam int CS_W = 5;
   localparam logic [CS_W-1:0] CS_INIT = 5'h1f;
endpackage

// [rtl/bus_sideband_if.sv]
`timescale 1ns/10ps
interface bus_sideband_if;
   import bus_sideband_pkg::*;
   logic bus_clk;
   logic bus_reset_n;
   logic supply_ok;
   logic [STRAP_W-1:0] strap_pins;
   logic [IRQ_W-1:0] local_irq_pins;
   logic priority_agent_bus_ask_n;
   logic debug_probe_ask_n;
   logic debug_probe_ack_n;
   logic thermal_alarm_n;
   logic power_status_out_n;
   logic [RESP_W-1:0] completion_code_n;
   // shared lines: each driver gives value and enable, pulled high when idle
   logic dev_lock_o;
   logic dev_lock_oe;
   logic lock_n;
   logic [CMD_W-1:0] dev_req_o;
   logic dev_req_oe;
   logic [CMD_W-1:0] cs_req_o;
   logic cs_req_oe;
   logic [CMD_W-1:0] req_n;
   logic dev_stb_o;
   logic dev_stb_oe;
   logic cs_stb_o;
   logic cs_stb_oe;
   logic addr_strobe0_n;

   assign lock_n = dev_lock_oe ? dev_lock_o : 1'b1;
   assign req_n = dev_req_oe ? dev_req_o : (cs_req_oe ? cs_req_o : CMD_IDLE_N);
   assign addr_strobe0_n = (dev_stb_oe & ~dev_stb_o) | (cs_stb_oe & ~cs_stb_o) ? 1'b0 : 1'b1;

   modport device (
      input bus_clk, bus_reset_n, supply_ok, strap_pins, local_irq_pins,
      input priority_agent_bus_ask_n, debug_probe_ask_n, completion_code_n,
      input lock_n, req_n, addr_strobe0_n,
      output debug_probe_ack_n, thermal_alarm_n, power_status_out_n,
      output dev_lock_o, dev_lock_oe, dev_req_o, dev_req_oe, dev_stb_o, dev_stb_oe
   );
   modport chipset (
      output bus_clk, bus_reset_n, supply_ok, strap_pins, local_irq_pins,
      output priority_agent_bus_ask_n, debug_probe_ask_n, completion_code_n,
      output cs_req_o, cs_req_oe, cs_stb_o, cs_stb_oe,
      input lock_n, req_n, addr_strobe0_n,
      input debug_probe_ack_n, thermal_alarm_n, power_status_out_n
   );
endinterface

// [rtl/sideband_sync.sv]
`timescale 1ns/10ps
module sideband_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t r;
   sync_state_t next_r;

   // first stage feeds only the second
   always_comb begin
      next_r.meta = i_async;
      next_r.stable = r.meta;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         r <= {INIT, INIT};
      end else begin
         r <= next_r;
      end
   end

   assign o_sync = r.stable;
endmodule

// [rtl/cpu_sideband_end.sv]
`timescale 1ns/10ps
// Summary of operation
// - controller off: pin0 maskable, pin1 nonmaskable
// - controller enabled again after every reset
// - interrupt pins treated as asynchronous inputs
// - lock held from first to last transaction
// - priority agent waits for lock release
// - thermal alarm when maximum temperature reached
// - power status low in deep sleeps
// - supply ok held low until stable
// - owner drives command lines with strobe
// - reset invalidates cache, no write-back
// - power-on reset held two milliseconds
// - bus outputs released within two clocks
// - straps valid before reset release, sampled
// - response agent drives completion code
// - probe request in, probe ready out
module cpu_sideband_end (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   bus_sideband_if.device bus,
   input wire logic i_irq_cfg_write,
   input wire logic i_irq_cfg_enable,
   input wire logic i_temp_max_reached,
   input wire logic i_deep_sleep,
   input wire logic i_deeper_sleep,
   input wire logic i_debug_ready,
   input wire logic i_txn_valid,
   input wire logic [bus_sideband_pkg::CMD_W-1:0] i_txn_type,
   input wire logic i_txn_lock,
   input wire logic i_txn_last,
   output logic o_txn_accept,
   output logic o_txn_done,
   output logic [bus_sideband_pkg::RESP_W-1:0] o_txn_status,
   output logic [bus_sideband_pkg::IRQ_W-1:0] o_local_irq,
   output logic o_maskable_irq_request,
   output logic o_nmi,
   output logic o_irq_ctrl_enabled,
   output logic o_debug_request,
   output logic o_cache_invalidate,
   output logic o_in_reset,
   output logic [bus_sideband_pkg::STRAP_W-1:0] o_straps
);
   import bus_sideband_pkg::*;

   typedef enum logic [1:0] {
      T_IDLE = 2'b00,
      T_DRIVE = 2'b01,
      T_WAIT = 2'b10
   } txn_state_t;

   typedef struct packed {
      txn_state_t st;
      logic bclk_prev;
      logic in_reset;
      logic irq_ctrl_en;
      logic last;
      logic [CMD_W-1:0] req_o;
      logic req_oe;
      logic stb_o;
      logic stb_oe;
      logic lock_o;
      logic lock_oe;
      logic thermal_n;
      logic psi_n;
      logic debug_probe_ack_n_n;
      logic [STRAP_W-1:0] straps;
      logic cache_inval;
      logic txn_accept;
      logic txn_done;
      logic [RESP_W-1:0] txn_status;
      logic [IRQ_W-1:0] local_irq;
      logic maskable_irq;
      logic nmi;
      logic debug_request;
   } dev_state_t;

   localparam dev_state_t DEV_RESET = '{
      st: T_IDLE,
      in_reset: 1'b1,
      irq_ctrl_en: IRQ_CTRL_EN_RESET,
      req_o: CMD_IDLE_N,
      stb_o: 1'b1,
      lock_o: 1'b1,
      thermal_n: 1'b1,
      psi_n: 1'b1,
      debug_probe_ack_n_n: 1'b1,
      default: '0
   };

   dev_state_t r;
   dev_state_t next_r;
   logic [DS_W-1:0] pins;
   logic [DS_W-1:0] s;
   logic rst_now;
   logic bclk_rise;
   logic bclk_fall;
   logic start_ok;

   assign pins[DS_BCLK] = bus.bus_clk;
   assign pins[DS_RST_N] = bus.bus_reset_n;
   assign pins[DS_SUPPLY] = bus.supply_ok;
   assign pins[DS_LINT +: IRQ_W] = bus.local_irq_pins;
   assign pins[DS_PRIORITY_AGENT_BUS_ASK_N_N] = bus.priority_agent_bus_ask_n;
   assign pins[DS_DEBUG_PROBE_ASK_N_N] = bus.debug_probe_ask_n;
   assign pins[DS_RESP +: RESP_W] = bus.completion_code_n;
   assign pins[DS_STRAP +: STRAP_W] = bus.strap_pins;

   // every pin, bus clock included, crosses into i_mclk here
   sideband_sync #(
      .WIDTH(DS_W),
      .INIT(DS_INIT)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_async(pins),
      .o_sync(s)
   );

   always_comb begin
      next_r = r;
      next_r.txn_accept = 1'b0;
      next_r.txn_done = 1'b0;
      next_r.cache_inval = 1'b0;
      // supply not ok counts as reset: protects against sequencing glitches
      rst_now = ~s[DS_RST_N] | ~s[DS_SUPPLY];
      bclk_rise = s[DS_BCLK] & ~r.bclk_prev;
      bclk_fall = ~s[DS_BCLK] & r.bclk_prev;
      // a locked sequence keeps the bus even against the priority agent
      start_ok = s[DS_PRIORITY_AGENT_BUS_ASK_N_N] | r.lock_oe;
      next_r.bclk_prev = s[DS_BCLK];
      next_r.in_reset = rst_now;

      next_r.thermal_n = ~i_temp_max_reached;
      next_r.psi_n = ~(i_deep_sleep | i_deeper_sleep);
      next_r.debug_request = ~s[DS_DEBUG_PROBE_ASK_N_N];
      next_r.debug_probe_ack_n_n = ~(i_debug_ready & ~s[DS_DEBUG_PROBE_ASK_N_N]);

      if (i_irq_cfg_write) begin
         next_r.irq_ctrl_en = i_irq_cfg_enable;
      end
      if (r.irq_ctrl_en) begin
         next_r.local_irq = s[DS_LINT +: IRQ_W];
         next_r.maskable_irq = 1'b0;
         next_r.nmi = 1'b0;
      end else begin
         next_r.local_irq = '0;
         next_r.maskable_irq = s[DS_LINT];
         next_r.nmi = s[DS_LINT + 1];
      end

      if (rst_now) begin
         // one invalidate pulse per reset entry, nothing written back
         next_r.cache_inval = ~r.in_reset;
         next_r.irq_ctrl_en = IRQ_CTRL_EN_RESET;
         next_r.st = T_IDLE;
         next_r.last = 1'b0;
         // released in the first i_mclk after the sampled reset
         next_r.req_o = CMD_IDLE_N;
         next_r.req_oe = 1'b0;
         next_r.stb_o = 1'b1;
         next_r.stb_oe = 1'b0;
         next_r.lock_o = 1'b1;
         next_r.lock_oe = 1'b0;
         next_r.debug_probe_ack_n_n = 1'b1;
         next_r.thermal_n = 1'b1;
         next_r.psi_n = 1'b1;
      end else begin
         if (r.in_reset) begin
            next_r.straps = s[DS_STRAP +: STRAP_W];
         end
         unique case (r.st)
            T_IDLE: begin
               if (bclk_fall && i_txn_valid && start_ok) begin
                  next_r.req_o = ~i_txn_type;
                  next_r.req_oe = 1'b1;
                  next_r.stb_o = 1'b0;
                  next_r.stb_oe = 1'b1;
                  next_r.lock_o = 1'b0;
                  next_r.lock_oe = r.lock_oe | i_txn_lock;
                  next_r.last = i_txn_last;
                  next_r.txn_accept = 1'b1;
                  next_r.st = T_DRIVE;
               end
            end
            T_DRIVE: begin
               if (bclk_fall) begin
                  next_r.req_o = CMD_IDLE_N;
                  next_r.req_oe = 1'b0;
                  next_r.stb_o = 1'b1;
                  next_r.stb_oe = 1'b0;
                  next_r.st = T_WAIT;
               end
            end
            T_WAIT: begin
               if (bclk_rise && (s[DS_RESP +: RESP_W] != RESP_IDLE_N)) begin
                  next_r.txn_status = ~s[DS_RESP +: RESP_W];
                  next_r.txn_done = 1'b1;
                  // lock stays until the last transaction of the sequence ends
                  if (r.last) begin
                     next_r.lock_oe = 1'b0;
                     next_r.lock_o = 1'b1;
                  end
                  next_r.st = T_IDLE;
               end
            end
            default: begin
               next_r.st = T_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         r <= DEV_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign bus.dev_req_o = r.req_o;
   assign bus.dev_req_oe = r.req_oe;
   assign bus.dev_stb_o = r.stb_o;
   assign bus.dev_stb_oe = r.stb_oe;
   assign bus.dev_lock_o = r.lock_o;
   assign bus.dev_lock_oe = r.lock_oe;
   assign bus.thermal_alarm_n = r.thermal_n;
   assign bus.power_status_out_n = r.psi_n;
   assign bus.debug_probe_ack_n = r.debug_probe_ack_n_n;
   assign o_txn_accept = r.txn_accept;
   assign o_txn_done = r.txn_done;
   assign o_txn_status = r.txn_status;
   assign o_local_irq = r.local_irq;
   assign o_maskable_irq_request = r.maskable_irq;
   assign o_nmi = r.nmi;
   assign o_irq_ctrl_enabled = r.irq_ctrl_en;
   assign o_debug_request = r.debug_request;
   assign o_cache_invalidate = r.cache_inval;
   assign o_in_reset = r.in_reset;
   assign o_straps = r.straps;
endmodule

// [rtl/chipset_sideband_end.sv]
`timescale 1ns/10ps
module chipset_sideband_end #(
   parameter int RESET_HOLD = bus_sideband_pkg::RESET_HOLD_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   bus_sideband_if.chipset bus,
   input wire logic i_supply_stable,
   input wire logic i_bus_reset_req,
   input wire logic [bus_sideband_pkg::STRAP_W-1:0] i_straps,
   input wire logic [bus_sideband_pkg::IRQ_W-1:0] i_local_irq,
   input wire logic i_debug_request,
   input wire logic i_txn_valid,
   input wire logic [bus_sideband_pkg::CMD_W-1:0] i_txn_type,
   input wire logic [bus_sideband_pkg::RESP_W-1:0] i_resp_code,
   output logic o_txn_accept,
   output logic o_txn_done,
   output logic o_resp_sent,
   output logic o_bus_reset_active,
   output logic o_dev_thermal_alarm,
   output logic o_dev_low_power,
   output logic o_dev_probe_ready
);
   import bus_sideband_pkg::*;

   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_ASK = 2'b01,
      C_WAIT = 2'b10,
      C_DRIVE = 2'b11
   } cs_state_t;

   typedef struct packed {
      cs_state_t st;
      logic [DIV_W-1:0] div_cnt;
      logic bclk;
      logic [HOLD_W-1:0] hold_cnt;
      logic rst_n;
      logic rst_act;
      logic supply_ok;
      logic [STRAP_W-1:0] straps;
      logic [IRQ_W-1:0] lint;
      logic priority_agent_bus_ask_n_n;
      logic debug_probe_ask_n_n;
      logic [CMD_W-1:0] req_o;
      logic req_oe;
      logic stb_o;
      logic stb_oe;
      logic [RESP_W-1:0] resp_o;
      logic resp_pend;
      logic resp_drive;
      logic txn_accept;
      logic txn_done;
      logic resp_sent;
      logic therm;
      logic low_power;
      logic probe_ready;
   } cs_state_rec_t;

   localparam cs_state_rec_t CS_RESET = '{
      st: C_IDLE,
      rst_act: 1'b1,
      priority_agent_bus_ask_n_n: 1'b1,
      debug_probe_ask_n_n: 1'b1,
      req_o: CMD_IDLE_N,
      stb_o: 1'b1,
      resp_o: RESP_IDLE_N,
      default: '0
   };
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD - 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BUS_HALF_CYCLES - 1);

   cs_state_rec_t r;
   cs_state_rec_t next_r;
   logic [CS_W-1:0] pins;
   logic [CS_W-1:0] s;
   logic fall;

   assign pins[CS_LOCK_N] = bus.lock_n;
   assign pins[CS_STB_N] = bus.addr_strobe0_n;
   assign pins[CS_THERM_N] = bus.thermal_alarm_n;
   assign pins[CS_PSI_N] = bus.power_status_out_n;
   assign pins[CS_DEBUG_PROBE_ACK_N_N] = bus.debug_probe_ack_n;

   sideband_sync #(
      .WIDTH(CS_W),
      .INIT(CS_INIT)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_async(pins),
      .o_sync(s)
   );

   always_comb begin
      next_r = r;
      next_r.txn_accept = 1'b0;
      next_r.txn_done = 1'b0;
      next_r.resp_sent = 1'b0;
      fall = 1'b0;
      // bus clock is made here by a divider of i_mclk
      if (r.div_cnt == DIV_LAST) begin
         next_r.div_cnt = '0;
         next_r.bclk = ~r.bclk;
         fall = r.bclk;
      end else begin
         next_r.div_cnt = r.div_cnt + 1'b1;
      end
      next_r.supply_ok = i_supply_stable;
      next_r.straps = i_straps;
      next_r.lint = i_local_irq;
      next_r.debug_probe_ask_n_n = ~i_debug_request;
      next_r.therm = ~s[CS_THERM_N];
      next_r.low_power = ~s[CS_PSI_N];
      next_r.probe_ready = ~s[CS_DEBUG_PROBE_ACK_N_N];

      if (~r.supply_ok | i_bus_reset_req) begin
         next_r.hold_cnt = '0;
         next_r.rst_n = 1'b0;
      end else if (r.hold_cnt != HOLD_LAST) begin
         next_r.hold_cnt = r.hold_cnt + 1'b1;
      end else begin
         next_r.rst_n = 1'b1;
      end

      next_r.rst_act = ~next_r.rst_n;

      if (~r.rst_n) begin
         next_r.st = C_IDLE;
         next_r.priority_agent_bus_ask_n_n = 1'b1;
         next_r.req_o = CMD_IDLE_N;
         next_r.req_oe = 1'b0;
         next_r.stb_o = 1'b1;
         next_r.stb_oe = 1'b0;
         next_r.resp_o = RESP_IDLE_N;
         next_r.resp_pend = 1'b0;
         next_r.resp_drive = 1'b0;
      end else if (fall) begin
         // answer a cpu request one bus clock after its strobe is seen
         if (r.resp_drive) begin
            next_r.resp_o = RESP_IDLE_N;
            next_r.resp_drive = 1'b0;
         end else if (r.resp_pend) begin
            next_r.resp_o = ~i_resp_code;
            next_r.resp_drive = 1'b1;
            next_r.resp_pend = 1'b0;
            next_r.resp_sent = 1'b1;
         end else if (~s[CS_STB_N] && ~r.stb_oe) begin
            next_r.resp_pend = 1'b1;
         end
         unique case (r.st)
            C_IDLE: begin
               if (i_txn_valid) begin
                  next_r.priority_agent_bus_ask_n_n = 1'b0;
                  next_r.req_o = ~i_txn_type;
                  next_r.txn_accept = 1'b1;
                  next_r.st = C_ASK;
               end
            end
            C_ASK: begin
               next_r.st = C_WAIT;
            end
            C_WAIT: begin
               // never take the bus while the cpu holds its lock
               if (s[CS_LOCK_N] && s[CS_STB_N]) begin
                  next_r.req_oe = 1'b1;
                  next_r.stb_o = 1'b0;
                  next_r.stb_oe = 1'b1;
                  next_r.st = C_DRIVE;
               end
            end
            C_DRIVE: begin
               next_r.req_o = CMD_IDLE_N;
               next_r.req_oe = 1'b0;
               next_r.stb_o = 1'b1;
               next_r.stb_oe = 1'b0;
               next_r.priority_agent_bus_ask_n_n = 1'b1;
               next_r.txn_done = 1'b1;
               next_r.st = C_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         r <= CS_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign bus.bus_clk = r.bclk;
   assign bus.bus_reset_n = r.rst_n;
   assign bus.supply_ok = r.supply_ok;
   assign bus.strap_pins = r.straps;
   assign bus.local_irq_pins = r.lint;
   assign bus.priority_agent_bus_ask_n = r.priority_agent_bus_ask_n_n;
   assign bus.debug_probe_ask_n = r.debug_probe_ask_n_n;
   assign bus.completion_code_n = r.resp_o;
   assign bus.cs_req_o = r.req_o;
   assign bus.cs_req_oe = r.req_oe;
   assign bus.cs_stb_o = r.stb_o;
   assign bus.cs_stb_oe = r.stb_oe;
   assign o_txn_accept = r.txn_accept;
   assign o_txn_done = r.txn_done;
   assign o_resp_sent = r.resp_sent;
   assign o_bus_reset_active = r.rst_act;
   assign o_dev_thermal_alarm = r.therm;
   assign o_dev_low_power = r.low_power;
   assign o_dev_probe_ready = r.probe_ready;
endmodule

// [sim/bus_sideband_sva.sv]
`timescale 1ns/10ps
module bus_sideband_sva (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic bus_reset_n,
   input wire logic lock_n,
   input wire logic addr_strobe0_n,
   input wire logic dev_lock_oe,
   input wire logic dev_req_oe,
   input wire logic dev_stb_oe,
   input wire logic dev_stb_o,
   input wire logic cs_req_oe,
   input wire logic cs_stb_oe,
   input wire logic cs_stb_o,
   input wire logic [bus_sideband_pkg::RESP_W-1:0] completion_code_n,
   input wire logic debug_probe_ask_n,
   input wire logic debug_probe_ack_n
);
   import bus_sideband_pkg::*;
   logic dev_stb;
   logic cs_stb;
   logic dev_off;
   assign dev_stb = dev_stb_oe & ~dev_stb_o;
   assign cs_stb = cs_stb_oe & ~cs_stb_o;
   assign dev_off = ~(dev_lock_oe | dev_req_oe | dev_stb_oe);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   // strobe and command lines go out together for one bus clock
   sequence s_stb_period;
      (dev_stb && dev_req_oe)[*8] ##[1:4] !dev_stb;
   endsequence
   property p_stb_len;
      $rose(dev_stb) |-> s_stb_period;
   endproperty
   a_stb_len: assert property (p_stb_len)
      else $error("strobe period wrong");
   // a locked sequence starts with the strobe and holds lock low for at least nine samples
   sequence s_lock_hold;
      !addr_strobe0_n ##1 !lock_n[*8];
   endsequence
   property p_lock_start;
      $fell(lock_n) |-> s_lock_hold;
   endproperty
   a_lock_start: assert property (p_lock_start)
      else $error("lock not tied to transaction");
   property p_lock_wait;
      !lock_n |-> !cs_stb;
   endproperty
   a_lock_wait: assert property (p_lock_wait)
      else $error("priority agent took locked bus");
   // six samples leave room for the two-flop synchroniser plus one register
   property p_dev_reset_off;
      !bus_reset_n[*6] |-> dev_off;
   endproperty
   a_dev_reset_off: assert property (p_dev_reset_off)
      else $error("cpu outputs kept in reset");
   property p_cs_reset_off;
      !bus_reset_n[*6] |-> !cs_req_oe && !cs_stb_oe && completion_code_n == RESP_IDLE_N;
   endproperty
   a_cs_reset_off: assert property (p_cs_reset_off)
      else $error("chipset outputs kept in reset");
   sequence s_resp_period;
      $stable(completion_code_n)[*8] ##[1:4] completion_code_n == RESP_IDLE_N;
   endsequence
   property p_resp_len;
      $rose(completion_code_n != RESP_IDLE_N) |-> ##1 s_resp_period;
   endproperty
   a_resp_len: assert property (p_resp_len)
      else $error("response not one bus clock");
   property p_probe_ack;
      $fell(debug_probe_ack_n) |-> !debug_probe_ask_n;
   endproperty
   a_probe_ack: assert property (p_probe_ack)
      else $error("probe ready without request");
   property p_probe_drop;
      $rose(debug_probe_ask_n) |-> ##[1:5] debug_probe_ack_n;
   endproperty
   a_probe_drop: assert property (p_probe_drop)
      else $error("probe ready kept after request");
endmodule

// [sim/cpu_bus_sideband_control_test.sv]
`timescale 1ns/10ps
module cpu_bus_sideband_control_test;
   import bus_sideband_pkg::*;
   localparam int HOLD = 20;
   logic i_mclk;
   logic i_sys_rst;
   logic irq_wr, irq_en, temp_max, deep, deeper, dbg_rdy, c_valid, c_lock, c_last;
   logic c_accept, c_done, c_irq_en, c_dbg_req, c_inv, c_in_rst, c_mask, c_nmi;
   logic s_stable, s_rst_req, s_dbg, s_valid, s_accept, s_done, s_rst_act;
   logic s_therm, s_lowp, s_debug_probe_ack_n, s_sent;
   logic [CMD_W-1:0] c_type, s_type, last_req;
   logic [RESP_W-1:0] c_status, s_code;
   logic [IRQ_W-1:0] c_lirq, s_lirq;
   logic [STRAP_W-1:0] c_straps, s_straps;
   logic [15:0] rows [7];
   int fails, num_checks, inv_cnt, hold_cnt, sent_cnt;
   time lock_end, cs_end;
   bus_sideband_if bus_link();
   cpu_sideband_end i_cpu_sideband_end (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_link),
      .i_irq_cfg_write(irq_wr), .i_irq_cfg_enable(irq_en), .i_temp_max_reached(temp_max),
      .i_deep_sleep(deep), .i_deeper_sleep(deeper), .i_debug_ready(dbg_rdy),
      .i_txn_valid(c_valid), .i_txn_type(c_type), .i_txn_lock(c_lock), .i_txn_last(c_last),
      .o_txn_accept(c_accept), .o_txn_done(c_done), .o_txn_status(c_status),
      .o_local_irq(c_lirq), .o_maskable_irq_request(c_mask), .o_nmi(c_nmi),
      .o_irq_ctrl_enabled(c_irq_en), .o_debug_request(c_dbg_req), .o_cache_invalidate(c_inv),
      .o_in_reset(c_in_rst), .o_straps(c_straps));
   chipset_sideband_end #(.RESET_HOLD(HOLD)) i_chipset_sideband_end (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .bus(bus_link), .i_supply_stable(s_stable),
      .i_bus_reset_req(s_rst_req), .i_straps(s_straps), .i_local_irq(s_lirq),
      .i_debug_request(s_dbg), .i_txn_valid(s_valid), .i_txn_type(s_type),
      .i_resp_code(s_code), .o_txn_accept(s_accept), .o_txn_done(s_done), .o_resp_sent(s_sent),
      .o_bus_reset_active(s_rst_act), .o_dev_thermal_alarm(s_therm),
      .o_dev_low_power(s_lowp), .o_dev_probe_ready(s_debug_probe_ack_n));
   bus_sideband_sva i_bus_sideband_sva (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .bus_reset_n(bus_link.bus_reset_n), .lock_n(bus_link.lock_n),
      .addr_strobe0_n(bus_link.addr_strobe0_n), .dev_lock_oe(bus_link.dev_lock_oe),
      .dev_req_oe(bus_link.dev_req_oe), .dev_stb_oe(bus_link.dev_stb_oe),
      .dev_stb_o(bus_link.dev_stb_o), .cs_req_oe(bus_link.cs_req_oe),
      .cs_stb_oe(bus_link.cs_stb_oe), .cs_stb_o(bus_link.cs_stb_o),
      .completion_code_n(bus_link.completion_code_n),
      .debug_probe_ask_n(bus_link.debug_probe_ask_n),
      .debug_probe_ack_n(bus_link.debug_probe_ack_n));
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end
   // command lines are only meaningful while the strobe is low
   always @(posedge i_mclk) begin
      if (bus_link.addr_strobe0_n === 1'b0) begin
         last_req <= bus_link.req_n;
      end
      if (c_inv === 1'b1) begin
         inv_cnt <= inv_cnt + 1;
      end
      if (s_sent === 1'b1) begin
         sent_cnt <= sent_cnt + 1;
      end
      if (bus_link.supply_ok === 1'b1 && bus_link.bus_reset_n === 1'b0) begin
         hold_cnt <= hold_cnt + 1;
      end
   end
   task automatic give_verdict();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic wait_lvl(ref logic s, input logic lvl, input int lim, input string what);
      int k;
      k = 0;
      while (s !== lvl && k < lim) begin
         step(1);
         k++;
      end
      if (s !== lvl) begin
         fails++;
         $display("[FAIL] %0t timeout %s", $time, what);
         give_verdict();
      end
   endtask
   task automatic cpu_txn(input logic [CMD_W-1:0] t, input logic lk, input logic ls,
         input logic [RESP_W-1:0] code);
      c_type = t;
      c_lock = lk;
      c_last = ls;
      s_code = code;
      c_valid = 1'b1;
      wait_lvl(c_accept, 1'b1, 200, "accept");
      c_valid = 1'b0;
      wait_lvl(c_done, 1'b1, 300, "done");
      chk({5'h00, c_status}, {5'h00, code}, "status");
      chk({3'h0, last_req}, {3'h0, ~t}, "command");
   endtask
   initial begin
      {fails, num_checks, inv_cnt, hold_cnt, sent_cnt} = '0;
      {irq_wr, irq_en, temp_max, deep, deeper, dbg_rdy, c_valid, c_lock, c_last} = '0;
      {s_stable, s_rst_req, s_dbg, s_valid, s_lirq, c_type, s_type} = '0;
      s_code = 3'h7;
      s_straps = 2'h2;
      i_sys_rst = 1'b1;
      rows = '{16'ha040, 16'hd088, 16'h2824, 16'h4615, 16'h6333, 16'hffcf, 16'h0000};
      step(12);
      i_sys_rst = 1'b0;
      step(2);
      chk({5'h00, s_rst_act, c_in_rst, c_irq_en}, 8'h07, "reset state");
      chk({3'h0, bus_link.req_n}, {3'h0, CMD_IDLE_N}, "idle command");
      s_stable = 1'b1;
      wait_lvl(c_in_rst, 1'b0, 400, "power-on release");
      chk({7'h00, hold_cnt >= HOLD}, 8'h01, "reset hold");
      chk({6'h00, c_straps}, 8'h02, "straps");
      chk(inv_cnt[7:0], 8'h00, "invalidate");
      for (int r = 0; r < 7; r++) begin
         {irq_en, s_lirq, temp_max, deep, deeper, s_dbg, dbg_rdy} = rows[r][15:8];
         irq_wr = 1'b1;
         step(1);
         irq_wr = 1'b0;
         step(30);
         chk({c_lirq, c_mask, c_nmi, s_therm, s_lowp, s_debug_probe_ack_n, c_dbg_req}, rows[r][7:0],
            "levels");
      end
      // pin seen only after the two synchroniser flops
      s_lirq = 2'h1;
      step(2);
      chk({7'h00, c_mask}, 8'h00, "irq too early");
      step(3);
      chk({7'h00, c_mask}, 8'h01, "irq late");
      cpu_txn(5'h0d, 1'b0, 1'b1, 3'h5);
      fork
         begin
            cpu_txn(5'h16, 1'b1, 1'b0, 3'h1);
            cpu_txn(5'h03, 1'b1, 1'b1, 3'h6);
            lock_end = $time;
         end
         begin
            wait_lvl(c_accept, 1'b1, 200, "lock start");
            s_type = 5'h0a;
            s_valid = 1'b1;
            wait_lvl(s_accept, 1'b1, 200, "chipset accept");
            s_valid = 1'b0;
            wait_lvl(s_done, 1'b1, 600, "chipset done");
            cs_end = $time;
         end
      join
      chk({7'h00, cs_end > lock_end}, 8'h01, "lock order");
      chk({3'h0, last_req}, {3'h0, ~5'h0a}, "chipset command");
      // bus reset in the middle of an unlocked transfer
      s_straps = 2'h1;
      c_type = 5'h11;
      c_lock = 1'b0;
      c_valid = 1'b1;
      wait_lvl(c_accept, 1'b1, 200, "accept before reset");
      c_valid = 1'b0;
      step(12);
      s_rst_req = 1'b1;
      step(8);
      chk({4'h0, s_rst_act, bus_link.dev_lock_oe, bus_link.dev_req_oe, bus_link.dev_stb_oe},
         8'h08, "released");
      s_rst_req = 1'b0;
      wait_lvl(c_in_rst, 1'b0, 400, "second release");
      chk(inv_cnt[7:0], 8'h01, "invalidate again");
      chk({7'h00, c_irq_en}, 8'h01, "controller on");
      chk({6'h00, c_straps}, 8'h01, "new straps");
      chk(sent_cnt[7:0], 8'h03, "responses");
      chk({7'h00, bus_link.supply_ok}, 8'h01, "supply held");
      give_verdict();
   end
endmodule
